// >>> bench/acc_analog_model.sv
`timescale 1ns/100ps
module acc_analog_model (
   input  wire logic        core_clk_i,
   input  wire logic [1:0]  on_i,
   input  wire logic [1:0]  hys_i,
   input  wire logic [15:0] vp_i,
   input  wire logic [15:0] vn_i,
   output logic      [1:0]  above_o
);
   logic [1:0] junk_reg = 2'h1;
   // An unpowered comparator chatters, so the design must mask it
   always_ff @(posedge core_clk_i) begin
      junk_reg <= ~junk_reg;
   end
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      wire [8:0] thr = {1'b0, vn_i[i*8+:8]} + (hys_i[i] ? 9'h004 : 9'h000);
      assign above_o[i] = on_i[i] ? ({1'b0, vp_i[i*8+:8]} > thr) : junk_reg[i];
   end
endmodule : acc_analog_model

// >>> bench/acc_top_checker.sv
`timescale 1ns/100ps
module acc_top_checker (
   input wire logic       core_clk_i,
   input wire logic       srst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [1:0] cmp_above_i,
   input wire logic       timer_clk_i,
   input wire logic [1:0] pin_direction_i,
   input wire logic [1:0] port_latch_i,
   input wire logic [1:0] cmp_pin_o,
   input wire logic [1:0] cmp_pin_oe_o,
   input wire logic [1:0] analog_on_o,
   input wire logic [1:0] speed_select_o,
   input wire logic [1:0] hysteresis_enable_o,
   input wire logic [3:0] pos_sel_o,
   input wire logic [3:0] neg_sel_o,
   input wire logic [1:0] cmp_result_o,
   input wire logic       irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence rd_at_s(logic [3:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   // Five quiet cycles cover the sync and timer-latch latency
   sequence quiet_s;
      (!reg_wr_i && $stable(cmp_above_i) && $stable(timer_clk_i)) [*5];
   endsequence
   oe_dir_a: assert property ((cmp_pin_oe_o & pin_direction_i) == 2'h0)
      else $error("pin driven while direction is input");
   latch_pass_a: assert property ((~analog_on_o & cmp_pin_oe_o & (cmp_pin_o ^ port_latch_i)) == 2'h0)
      else $error("pin differs from port latch while comparator off");
   rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
   mirror_read_a: assert property (rd_at_s(4'h4) |=> reg_rdata_o == {6'h00, $past(cmp_result_o)})
      else $error("mirror read mismatch");
   ctrl_read_a: assert property (rd_at_s(4'h0) |=>
      reg_rdata_o[7:6] == {$past(analog_on_o[0]), $past(cmp_result_o[0])} &&
      reg_rdata_o[2:1] == {$past(speed_select_o[0]), $past(hysteresis_enable_o[0])})
      else $error("first control read mismatch");
   sel_read_a: assert property (rd_at_s(4'h3) |=> !$past(analog_on_o[1]) ||
      reg_rdata_o[5:0] == {$past(pos_sel_o[3:2]), 2'h0, $past(neg_sel_o[3:2])})
      else $error("second comparator select read mismatch");
   sel_off_a: assert property (!analog_on_o[0] |-> pos_sel_o[1:0] == 2'h0 && neg_sel_o[1:0] == 2'h0)
      else $error("inputs selected while comparator off");
   result_hold_a: assert property (quiet_s |=> $stable(cmp_result_o))
      else $error("result moved without cause");
   reset_val_a: assert property ($fell(srst_i) |-> speed_select_o == 2'h3 && analog_on_o == 2'h0 && !irq_o)
      else $error("wrong state after reset");
endmodule : acc_top_checker

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
   logic        core_clk_i, srst_i, reg_wr_i, reg_rd_i, timer_clk_i, irq_o;
   logic [3:0]  reg_addr_i, pos_sel_o, neg_sel_o;
   logic [7:0]  reg_wdata_i, reg_rdata_o;
   logic [1:0]  cmp_above_i, pin_direction_i, port_latch_i, cmp_pin_o, cmp_pin_oe_o;
   logic [1:0]  analog_on_o, speed_select_o, hysteresis_enable_o, cmp_result_o;
   logic [15:0] vp, vn;
   int          err_count, checks_done;
   acc_top uut (.*);
   acc_analog_model pm (.core_clk_i(core_clk_i), .on_i(analog_on_o),
      .hys_i(hysteresis_enable_o), .vp_i(vp), .vn_i(vn), .above_o(cmp_above_i));
   always #2 core_clk_i = ~core_clk_i;
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task cmp(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1 cmp(reg_rdata_o, e);
   endtask : rd
   // Pulls the timer clock low once and gives the latch time to settle
   task tfall;
      @(posedge core_clk_i) timer_clk_i <= 1'b0;
      tick(5);
      @(posedge core_clk_i) timer_clk_i <= 1'b1;
      tick(5);
   endtask : tfall
   initial begin
      core_clk_i = 0; srst_i = 1; reg_wr_i = 0; reg_rd_i = 0; reg_addr_i = 4'h0;
      reg_wdata_i = 8'h00; timer_clk_i = 1; pin_direction_i = 2'h0; port_latch_i = 2'h2;
      vp = 16'h0000; vn = 16'h8080; err_count = 0; checks_done = 0;
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'b0;
      for (int k = 0; k < 9; k++) rd(4'(k), (k == 0 || k == 2) ? 8'h04 : 8'h00);
      cmp({speed_select_o, cmp_pin_oe_o, 2'h0, cmp_pin_o}, 8'hF2);
      wr(4'h1, 8'h80);
      wr(4'h7, 8'h01);
      wr(4'h0, 8'h14);
      tick(4);
      cmp({7'h00, cmp_result_o[0]}, 8'h01);
      rd(4'h5, 8'h01);
      cmp({7'h00, irq_o}, 8'h01);
      wr(4'h7, 8'h00);
      tick(1);
      cmp({7'h00, irq_o}, 8'h00);
      wr(4'h7, 8'h01);
      wr(4'h6, 8'h01);
      rd(4'h5, 8'h00);
      wr(4'h0, 8'hA4);
      tick(4);
      @(posedge core_clk_i) vp <= 16'h00C0;
      tick(2);
      cmp({6'h00, cmp_pin_o[0], cmp_result_o[0]}, 8'h02);
      tick(2);
      rd(4'h4, 8'h01);
      rd(4'h0, 8'hE4);
      cmp({7'h00, irq_o}, 8'h01);
      wr(4'h0, 8'hB4);
      tick(2);
      cmp({7'h00, cmp_result_o[0]}, 8'h00);
      wr(4'h0, 8'hA5);
      tfall();
      @(posedge core_clk_i) vp <= 16'h0000;
      tick(6);
      cmp({7'h00, cmp_pin_o[0]}, 8'h01);
      tfall();
      cmp({7'h00, cmp_pin_o[0]}, 8'h00);
      wr(4'h0, 8'h34);
      tick(1);
      cmp({6'h00, cmp_pin_oe_o[0], cmp_pin_o[0]}, 8'h01);
      wr(4'h0, 8'hA4);
      @(posedge core_clk_i) pin_direction_i <= 2'h3;
      tick(1);
      cmp({6'h00, cmp_pin_oe_o}, 8'h00);
      wr(4'h2, 8'h82);
      wr(4'h3, 8'h32);
      @(posedge core_clk_i) vp <= 16'hC0C0;
      rd(4'h3, 8'h32);
      cmp({pos_sel_o, neg_sel_o}, 8'hC8);
      cmp({speed_select_o, hysteresis_enable_o, analog_on_o, 2'h0}, 8'h6C);
      tick(6);
      rd(4'h4, 8'h03);
      wrap_up();
   end
   initial begin
      #5000;
      err_count++;
      wrap_up();
   end
endmodule : tb
bind acc_top acc_top_checker chk (.*);

// >>> hdl/acc_cmp_chan.sv
`timescale 1ns/100ps
module acc_cmp_chan
   import acc_pkg::*;
(
   input  wire logic      core_clk_i,
   input  wire logic      srst_i,
   input  wire acc_ctrl_s ctrl_i,
   input  wire logic      above_sync_i,
   input  wire logic      timer_fall_i,
   output acc_chan_out_s  out_o
);

   logic result_reg;
   logic result_next;
   logic result_prev_reg;
   logic tsync_reg;
   logic tsync_next;
   wire  gated_raw;
   wire  polar_val;
   wire  live_val;

   // A disabled comparator reads low before the polarity stage, so toggling
   // the polarity or the enable still yields an edge, as on the real part.
   assign gated_raw = ctrl_i.on & above_sync_i;
   assign polar_val = gated_raw ^ ctrl_i.pol;

   // Latched on the falling edge of the prescaled timer clock
   assign tsync_next = timer_fall_i ? polar_val : tsync_reg;
   assign live_val   = ctrl_i.sync ? tsync_reg : polar_val;

   assign result_next = live_val;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         result_reg      <= 1'b0;
         result_prev_reg <= 1'b0;
         tsync_reg       <= 1'b0;
      end else begin
         result_reg      <= result_next;
         result_prev_reg <= result_reg;
         tsync_reg       <= tsync_next;
      end
   end

   assign out_o.result  = result_reg;
   assign out_o.pin_val = live_val;
   assign out_o.rise    = result_reg & ~result_prev_reg;
   assign out_o.fall    = ~result_reg & result_prev_reg;

endmodule : acc_cmp_chan

// >>> hdl/acc_pkg.sv
package acc_pkg;

   typedef logic [7:0] acc_byte_t;

   typedef struct packed {
      logic       on;
      logic       oe;
      logic       pol;
      logic       sp;
      logic       hys;
      logic       sync;
      logic       rise_en;
      logic       fall_en;
      logic [1:0] pos_ch;
      logic [1:0] neg_ch;
   } acc_ctrl_s;

   typedef struct packed {
      logic       result;
      logic       pin_val;
      logic       rise;
      logic       fall;
   } acc_chan_out_s;

endpackage : acc_pkg

// >>> hdl/acc_regs.svh
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register offsets on the 4-bit register port
`define ACC_OFS_CTRL0_C1    4'h0
`define ACC_OFS_CTRL1_C1    4'h1
`define ACC_OFS_CTRL0_C2    4'h2
`define ACC_OFS_CTRL1_C2    4'h3
`define ACC_OFS_MIRROR      4'h4
`define ACC_OFS_IRQ_STATUS  4'h5
`define ACC_OFS_IRQ_CLEAR   4'h6
`define ACC_OFS_IRQ_ENABLE  4'h7

// cmp_control_first field positions
`define ACC_C0_ON           7
`define ACC_C0_RESULT       6
`define ACC_C0_OE           5
`define ACC_C0_POL          4
`define ACC_C0_SP           2
`define ACC_C0_HYS          1
`define ACC_C0_SYNC         0

// cmp_control_second field positions
`define ACC_C1_RISE         7
`define ACC_C1_FALL         6
`define ACC_C1_PCH_LSB      4
`define ACC_C1_NCH_LSB      0

// Reset values
`define ACC_RST_CTRL0       8'h04
`define ACC_RST_CTRL1       8'h00
`define ACC_RST_IRQ_ENABLE  2'h0

// Number of comparator instances
`define ACC_NUM_CMP         2

`endif

// >>> hdl/acc_sync2.sv
`timescale 1ns/100ps
module acc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // First stage is read only by the second stage
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule : acc_sync2

// >>> hdl/acc_top.sv
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_top
   import acc_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic [1:0] cmp_above_i,
   input  wire logic       timer_clk_i,
   input  wire logic [1:0] pin_direction_i,
   input  wire logic [1:0] port_latch_i,
   output logic      [1:0] cmp_pin_o,
   output logic      [1:0] cmp_pin_oe_o,
   output logic      [1:0] analog_on_o,
   output logic      [1:0] speed_select_o,
   output logic      [1:0] hysteresis_enable_o,
   output logic      [3:0] pos_sel_o,
   output logic      [3:0] neg_sel_o,
   output logic      [1:0] cmp_result_o,
   output logic            irq_o
);

   localparam int NCMP = `ACC_NUM_CMP;

   localparam acc_byte_t RST_C0 = `ACC_RST_CTRL0;
   localparam acc_byte_t RST_C1 = `ACC_RST_CTRL1;

   // Reset image built field by field from the register reset bytes, so the
   // struct order can never shift speed_select away from its normal-speed default
   localparam acc_ctrl_s CTRL_RST = '{
      on:      RST_C0[`ACC_C0_ON],
      oe:      RST_C0[`ACC_C0_OE],
      pol:     RST_C0[`ACC_C0_POL],
      sp:      RST_C0[`ACC_C0_SP],
      hys:     RST_C0[`ACC_C0_HYS],
      sync:    RST_C0[`ACC_C0_SYNC],
      rise_en: RST_C1[`ACC_C1_RISE],
      fall_en: RST_C1[`ACC_C1_FALL],
      pos_ch:  RST_C1[`ACC_C1_PCH_LSB+1:`ACC_C1_PCH_LSB],
      neg_ch:  RST_C1[`ACC_C1_NCH_LSB+1:`ACC_C1_NCH_LSB]
   };

   // Write strobe decode for one offset
   function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
                                   input logic [3:0] ofs);
      wr_hit = wr & (addr == ofs);
   endfunction : wr_hit

   // Maps a comparator index onto its two control register offsets
   function automatic logic [3:0] ctrl_ofs(input int idx, input logic second);
      logic [3:0] base;
      base = (idx == 0) ? `ACC_OFS_CTRL0_C1 : `ACC_OFS_CTRL0_C2;
      ctrl_ofs = second ? (base + 4'h1) : base;
   endfunction : ctrl_ofs

   // Builds the readable image of cmp_control_first
   function automatic acc_byte_t ctrl0_image(input acc_ctrl_s c, input logic res);
      acc_byte_t img;
      img                = 8'h00;
      img[`ACC_C0_ON]    = c.on;
      img[`ACC_C0_RESULT] = res;
      img[`ACC_C0_OE]    = c.oe;
      img[`ACC_C0_POL]   = c.pol;
      img[`ACC_C0_SP]    = c.sp;
      img[`ACC_C0_HYS]   = c.hys;
      img[`ACC_C0_SYNC]  = c.sync;
      ctrl0_image = img;
   endfunction : ctrl0_image

   // Builds the readable image of cmp_control_second
   function automatic acc_byte_t ctrl1_image(input acc_ctrl_s c);
      acc_byte_t img;
      img                                     = 8'h00;
      img[`ACC_C1_RISE]                       = c.rise_en;
      img[`ACC_C1_FALL]                       = c.fall_en;
      img[`ACC_C1_PCH_LSB+1:`ACC_C1_PCH_LSB] = c.pos_ch;
      img[`ACC_C1_NCH_LSB+1:`ACC_C1_NCH_LSB] = c.neg_ch;
      ctrl1_image = img;
   endfunction : ctrl1_image

   acc_ctrl_s       ctrl_reg    [NCMP];
   acc_ctrl_s       ctrl_next   [NCMP];
   acc_chan_out_s   chan_out    [NCMP];
   logic [1:0]      irq_status_reg;
   logic [1:0]      irq_status_next;
   logic [1:0]      irq_enable_reg;
   logic [1:0]      irq_enable_next;
   acc_byte_t       rdata_reg;
   acc_byte_t       rdata_next;
   acc_byte_t       img_first   [NCMP];
   acc_byte_t       img_second  [NCMP];

   wire  [1:0]      above_sync;
   wire             tclk_sync;
   logic            tclk_prev_reg;
   wire             timer_fall;

   wire             wr_irq_clear;
   wire             wr_irq_enable;
   wire  [1:0]      irq_set;
   wire  [1:0]      irq_clr;
   wire  [1:0]      mirror_bits;
   wire  [1:0]      sel_ctrl0;
   wire  [1:0]      sel_ctrl1;
   wire             hit_mirror;
   wire             hit_status;
   wire             hit_enable;

   // Analog result and timer clock come from outside the core clock domain
   acc_sync2 #(
      .WIDTH (2)
   ) u_sync_above (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .async_i    (cmp_above_i),
      .sync_o     (above_sync)
   );

   acc_sync2 #(
      .WIDTH (1)
   ) u_sync_tclk (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .async_i    (timer_clk_i),
      .sync_o     (tclk_sync)
   );

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tclk_prev_reg <= 1'b0;
      end else begin
         tclk_prev_reg <= tclk_sync;
      end
   end

   // The timer counts on the rising edge, so latching on the falling one
   // leaves half a timer period for the gate value to settle.
   assign timer_fall = tclk_prev_reg & ~tclk_sync;

   genvar g;
   generate
      for (g = 0; g < NCMP; g++) begin : g_cmp
         wire wr_c0;
         wire wr_c1;
         wire rd_hit_c0;
         wire rd_hit_c1;

         assign wr_c0     = wr_hit(reg_wr_i, reg_addr_i, ctrl_ofs(g, 1'b0));
         assign wr_c1     = wr_hit(reg_wr_i, reg_addr_i, ctrl_ofs(g, 1'b1));
         assign rd_hit_c0 = reg_addr_i == ctrl_ofs(g, 1'b0);
         assign rd_hit_c1 = reg_addr_i == ctrl_ofs(g, 1'b1);
         assign sel_ctrl0[g] = rd_hit_c0;
         assign sel_ctrl1[g] = rd_hit_c1;

         always_comb begin
            ctrl_next[g] = ctrl_reg[g];
            if (wr_c0) begin
               ctrl_next[g].on   = reg_wdata_i[`ACC_C0_ON];
               ctrl_next[g].oe   = reg_wdata_i[`ACC_C0_OE];
               ctrl_next[g].pol  = reg_wdata_i[`ACC_C0_POL];
               ctrl_next[g].sp   = reg_wdata_i[`ACC_C0_SP];
               ctrl_next[g].hys  = reg_wdata_i[`ACC_C0_HYS];
               ctrl_next[g].sync = reg_wdata_i[`ACC_C0_SYNC];
            end
            if (wr_c1) begin
               ctrl_next[g].rise_en = reg_wdata_i[`ACC_C1_RISE];
               ctrl_next[g].fall_en = reg_wdata_i[`ACC_C1_FALL];
               ctrl_next[g].pos_ch  = reg_wdata_i[`ACC_C1_PCH_LSB+1:`ACC_C1_PCH_LSB];
               ctrl_next[g].neg_ch  = reg_wdata_i[`ACC_C1_NCH_LSB+1:`ACC_C1_NCH_LSB];
            end
         end

         always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
               ctrl_reg[g] <= CTRL_RST;
            end else begin
               ctrl_reg[g] <= ctrl_next[g];
            end
         end

         acc_cmp_chan u_chan (
            .core_clk_i   (core_clk_i),
            .srst_i       (srst_i),
            .ctrl_i       (ctrl_reg[g]),
            .above_sync_i (above_sync[g]),
            .timer_fall_i (timer_fall),
            .out_o        (chan_out[g])
         );

         wire pin_sel;
         wire drive_en;

         // Override follows pin_output_enable alone; comparator_on only gates the driver
         assign pin_sel         = ctrl_reg[g].oe ? chan_out[g].pin_val
                                                 : port_latch_i[g];
         assign drive_en        = ~ctrl_reg[g].oe | ctrl_reg[g].on;
         assign cmp_pin_o[g]    = pin_sel;
         assign cmp_pin_oe_o[g] = ~pin_direction_i[g] & drive_en;

         assign analog_on_o[g]         = ctrl_reg[g].on;
         assign speed_select_o[g]      = ctrl_reg[g].sp;
         assign hysteresis_enable_o[g] = ctrl_reg[g].hys;
         assign pos_sel_o[2*g+1:2*g]   = ctrl_reg[g].on ? ctrl_reg[g].pos_ch : 2'h0;
         assign neg_sel_o[2*g+1:2*g]   = ctrl_reg[g].on ? ctrl_reg[g].neg_ch : 2'h0;
         assign cmp_result_o[g]        = chan_out[g].result;
         assign mirror_bits[g]         = chan_out[g].result;

         assign irq_set[g] = (chan_out[g].rise & ctrl_reg[g].rise_en)
                             | (chan_out[g].fall & ctrl_reg[g].fall_en);
         assign irq_clr[g] = wr_irq_clear & reg_wdata_i[g];

         assign img_first[g]  = ctrl0_image(ctrl_reg[g], chan_out[g].result);
         assign img_second[g] = ctrl1_image(ctrl_reg[g]);
      end
   endgenerate

   // Interrupt status, clear and enable
   assign wr_irq_clear  = wr_hit(reg_wr_i, reg_addr_i, `ACC_OFS_IRQ_CLEAR);
   assign wr_irq_enable = wr_hit(reg_wr_i, reg_addr_i, `ACC_OFS_IRQ_ENABLE);

   // Set wins over a clear in the same cycle so no edge is lost
   assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
   assign irq_enable_next = wr_irq_enable ? reg_wdata_i[1:0] : irq_enable_reg;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_status_reg <= 2'h0;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_enable_reg <= `ACC_RST_IRQ_ENABLE;
      end else begin
         irq_enable_reg <= irq_enable_next;
      end
   end

   assign irq_o = |(irq_status_reg & irq_enable_reg);

   // Shared registers of the read path
   assign hit_mirror = reg_addr_i == `ACC_OFS_MIRROR;
   assign hit_status = reg_addr_i == `ACC_OFS_IRQ_STATUS;
   assign hit_enable = reg_addr_i == `ACC_OFS_IRQ_ENABLE;

   // Read path; write-only and unmapped offsets read as zero
   always_comb begin
      rdata_next = 8'h00;
      for (int i = 0; i < NCMP; i++) begin
         if (sel_ctrl0[i]) begin
            rdata_next = img_first[i];
         end
         if (sel_ctrl1[i]) begin
            rdata_next = img_second[i];
         end
      end
      if (hit_mirror) begin
         rdata_next = {6'h00, mirror_bits};
      end
      if (hit_status) begin
         rdata_next = {6'h00, irq_status_reg};
      end
      if (hit_enable) begin
         rdata_next = {6'h00, irq_enable_reg};
      end
   end

   // Data stand for one cycle only, so a stale value can never pass
   // for the answer to a later read

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_reg;

endmodule : acc_top
